/* File: design/dad_pkg.sv */
/*
 * Shared constants and types for the dual-channel converter output and
 * configuration port: register indices, field positions, reset values,
 * output formats and the serial-port states.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package dad_pkg;

	// ------------------------------------------------------------------
	// widths
	// ------------------------------------------------------------------
	localparam int DAD_SAMPLE_W = 16;
	localparam int DAD_PAIR_W   = 8;
	localparam int DAD_REG_W    = 8;
	localparam int DAD_SYNC_N   = 7;

	// ------------------------------------------------------------------
	// serial frame: read flag, 7-bit index, 8 data bits
	// ------------------------------------------------------------------
	localparam logic [4:0] DAD_FRAME_BITS = 5'h10;
	localparam logic [4:0] DAD_HEAD_BITS  = 5'h08;

	// ------------------------------------------------------------------
	// mode control register indices
	// ------------------------------------------------------------------
	localparam logic [6:0] DAD_REG_POWER  = 7'h00;
	localparam logic [6:0] DAD_REG_TIMING = 7'h01;
	localparam logic [6:0] DAD_REG_OUTPUT = 7'h02;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int DAD_POW_LSB   = 0;
	localparam int DAD_DCS_BIT   = 0;
	localparam int DAD_PHASE_LSB = 1;
	localparam int DAD_MODE_LSB  = 0;
	localparam int DAD_CUR_LSB   = 2;
	localparam int DAD_TERM_BIT  = 5;

	// ------------------------------------------------------------------
	// values after reset, and the fixed current used in parallel mode
	// ------------------------------------------------------------------
	localparam logic [7:0] DAD_POWER_RST  = 8'h00;
	localparam logic [7:0] DAD_TIMING_RST = 8'h00;
	localparam logic [7:0] DAD_OUTPUT_RST = 8'h00;
	localparam logic [2:0] DAD_CUR_PAR    = 3'h0;

	// ------------------------------------------------------------------
	// strap capture: cycles after release before the strap is taken
	// ------------------------------------------------------------------
	localparam logic [1:0] DAD_STRAP_WAIT = 2'h3;

	// ------------------------------------------------------------------
	// power states
	// ------------------------------------------------------------------
	localparam logic [1:0] DAD_POW_RUN   = 2'h0;
	localparam logic [1:0] DAD_POW_SLEEP = 2'h3;

	typedef enum logic [1:0] {
		DAD_FULL_CMOS = 2'b00,
		DAD_DDR_CMOS  = 2'b01,
		DAD_DDR_LVDS  = 2'b10
	} dad_out_mode_t;

	typedef enum logic [1:0] {
		DAD_SPI_IDLE = 2'b00,
		DAD_SPI_HEAD = 2'b01,
		DAD_SPI_DATA = 2'b10,
		DAD_SPI_DONE = 2'b11
	} dad_spi_state_t;

endpackage

/* File: design/dad_cfg_if.sv */
/*
 * Carrier between the top of the port and its serial register block:
 * synchronised pin levels one way, mode register contents the other.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface dad_cfg_if;
	logic       csN;
	logic       sck;
	logic       sdi;
	logic       sdoLow;
	logic [7:0] powerReg;
	logic [7:0] timingReg;
	logic [7:0] outputReg;

	modport core (output csN, output sck, output sdi,
		input sdoLow, input powerReg, input timingReg, input outputReg);
	modport regs (input csN, input sck, input sdi,
		output sdoLow, output powerReg, output timingReg, output outputReg);
endinterface

/* File: design/dad_serial_regs.sv */
/*
 * Serial mode control registers: shifts a 16-bit frame in on rising
 * serial-clock edges while select is low, answers reads on falling edges.
 * Assumes already synchronised pin levels on the carrier.
 */
`timescale 1ns/1ps
module dad_serial_regs (
	// system
	input wire logic clock,
	input wire logic reset_n,
	// carrier
	dad_cfg_if.regs  cfg
);
	dad_pkg::dad_spi_state_t state;
	logic                    sckPrev;
	logic [4:0]              bitCount;
	logic [15:0]             shiftIn;
	logic [7:0]              shiftOut;
	logic                    sckRise;
	logic                    sckFall;
	logic [15:0]             nextShift;

	assign sckRise   = cfg.sck & ~sckPrev;
	assign sckFall   = ~cfg.sck & sckPrev;
	assign nextShift = {shiftIn[14:0], cfg.sdi};

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sckPrev <= 1'b0;
		end else begin
			sckPrev <= cfg.sck;
		end
	end

	// ------------------------------------------------------------------
	// frame sequencing
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state    <= dad_pkg::DAD_SPI_IDLE;
			bitCount <= 5'h00;
			shiftIn  <= 16'h0000;
		end else if (cfg.csN) begin
			state    <= dad_pkg::DAD_SPI_IDLE;
			bitCount <= 5'h00;
		end else if (sckRise) begin
			shiftIn  <= nextShift;
			bitCount <= bitCount + 5'h01;
			case (state)
				dad_pkg::DAD_SPI_IDLE: begin
					state <= dad_pkg::DAD_SPI_HEAD;
				end
				dad_pkg::DAD_SPI_HEAD: begin
					if (bitCount + 5'h01 == dad_pkg::DAD_HEAD_BITS) begin
						state <= dad_pkg::DAD_SPI_DATA;
					end
				end
				dad_pkg::DAD_SPI_DATA: begin
					if (bitCount + 5'h01 == dad_pkg::DAD_FRAME_BITS) begin
						state <= dad_pkg::DAD_SPI_DONE;
					end
				end
				dad_pkg::DAD_SPI_DONE: begin
					state <= dad_pkg::DAD_SPI_DONE;
				end
				default: begin
					state <= dad_pkg::DAD_SPI_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// register writes on the last rising edge of a write frame
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cfg.powerReg  <= dad_pkg::DAD_POWER_RST;
			cfg.timingReg <= dad_pkg::DAD_TIMING_RST;
			cfg.outputReg <= dad_pkg::DAD_OUTPUT_RST;
		end else if (!cfg.csN && sckRise && state == dad_pkg::DAD_SPI_DATA
			&& bitCount + 5'h01 == dad_pkg::DAD_FRAME_BITS && !nextShift[15]) begin
			case (nextShift[14:8])
				dad_pkg::DAD_REG_POWER:  cfg.powerReg  <= nextShift[7:0];
				dad_pkg::DAD_REG_TIMING: cfg.timingReg <= nextShift[7:0];
				dad_pkg::DAD_REG_OUTPUT: cfg.outputReg <= nextShift[7:0];
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// readback: loaded after the header, shifted out on falling edges
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			shiftOut   <= 8'h00;
			cfg.sdoLow <= 1'b0;
		end else if (cfg.csN) begin
			cfg.sdoLow <= 1'b0;
		end else if (sckRise && state == dad_pkg::DAD_SPI_HEAD
			&& bitCount + 5'h01 == dad_pkg::DAD_HEAD_BITS) begin
			case (nextShift[6:0])
				dad_pkg::DAD_REG_POWER:  shiftOut <= cfg.powerReg;
				dad_pkg::DAD_REG_TIMING: shiftOut <= cfg.timingReg;
				dad_pkg::DAD_REG_OUTPUT: shiftOut <= cfg.outputReg;
				default:                 shiftOut <= 8'h00;
			endcase
			// write frames keep the line released
			if (!nextShift[7]) begin
				shiftOut <= 8'hFF;
			end
		end else if (sckFall && state == dad_pkg::DAD_SPI_DATA) begin
			cfg.sdoLow <= ~shiftOut[7];
			shiftOut   <= {shiftOut[6:0], 1'b1};
		end else if (sckFall) begin
			cfg.sdoLow <= 1'b0;
		end
	end
endmodule

/* File: design/dad_converter_port.sv */
/*
 * Output and configuration port of a two-channel simultaneous-sampling
 * 16-bit converter: sample capture on encode, full-rate or double-rate
 * formatting, forwarded output clock, range flags, strap-selected serial
 * or parallel configuration.
 * Assumes converter words and range flags from the analog side on this
 * clock, held steady across the encode rising edge; all pins asynchronous.
 */
`timescale 1ns/1ps
module dad_converter_port (
	// system
	input  wire logic        clock,
	input  wire logic        reset_n,
	// encode pins
	input  wire logic        encodeClkPos,
	input  wire logic        encodeClkNeg,
	// converter results
	input  wire logic [15:0] ch1Conv,
	input  wire logic [15:0] ch2Conv,
	input  wire logic        ch1OverRange,
	input  wire logic        ch2OverRange,
	// configuration pins
	input  wire logic        progModeStrap,
	input  wire logic        csN,
	input  wire logic        sck,
	input  wire logic        sdi,
	input  wire logic        sdoIn,
	output logic             sdoOut,
	output logic             sdoOe,
	// full-rate outputs
	output logic [15:0]      ch1SampleBus,
	output logic [15:0]      ch2SampleBus,
	output logic             ch1RangeFlag,
	output logic             ch2RangeFlag,
	// double-rate outputs
	output logic [7:0]       ch1PairedBus,
	output logic [7:0]       ch2PairedBus,
	output logic             sharedRangeFlag,
	// forwarded clock
	output logic             fwdClockTrue,
	output logic             fwdClockComp,
	// mode to the analog side
	output logic [1:0]       outputFormat,
	output logic             dcsEnable,
	output logic [1:0]       powerState,
	output logic [2:0]       lvdsCurrent,
	output logic             lvdsTermEnable,
	output logic             serialMode
);
	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [dad_pkg::DAD_SYNC_N-1:0] pinRaw;
	logic [dad_pkg::DAD_SYNC_N-1:0] pinMeta;
	logic [dad_pkg::DAD_SYNC_N-1:0] pinSync;

	assign pinRaw = {sdoIn, sdi, sck, csN, progModeStrap, encodeClkNeg, encodeClkPos};

	// select idles high so no frame is seen before the pins settle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta <= 7'h08;
			pinSync <= 7'h08;
		end else begin
			pinMeta <= pinRaw;
			pinSync <= pinMeta;
		end
	end

	// ------------------------------------------------------------------
	// strap capture after reset release
	// ------------------------------------------------------------------
	logic [1:0] strapWait;
	logic       strapTaken;
	logic       parallelMode;

	// the strap is static, so one capture after release is enough
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			strapWait    <= 2'h0;
			strapTaken   <= 1'b0;
			parallelMode <= 1'b0;
		end else if (!strapTaken) begin
			strapWait <= strapWait + 2'h1;
			if (strapWait == dad_pkg::DAD_STRAP_WAIT) begin
				strapTaken   <= 1'b1;
				parallelMode <= pinSync[2];
			end
		end
	end

	// ------------------------------------------------------------------
	// serial register block
	// ------------------------------------------------------------------
	dad_cfg_if cfgBus ();

	// parallel mode parks the serial block with select high
	assign cfgBus.csN = pinSync[3] | parallelMode | ~strapTaken;
	assign cfgBus.sck = pinSync[4];
	assign cfgBus.sdi = pinSync[5];

	dad_serial_regs serialRegs (
		.clock   (clock),
		.reset_n (reset_n),
		.cfg     (cfgBus.regs)
	);

	// open drain: only ever pulls low, and never in parallel mode
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sdoOut <= 1'b0;
			sdoOe  <= 1'b0;
		end else begin
			sdoOut <= 1'b0;
			sdoOe  <= cfgBus.sdoLow & ~parallelMode;
		end
	end

	// ------------------------------------------------------------------
	// effective configuration
	// ------------------------------------------------------------------
	logic [1:0] next_format;
	logic       next_dcs;
	logic [1:0] next_power;
	logic [2:0] next_current;
	logic       next_term;
	logic [1:0] next_phase;
	logic [1:0] phaseSel;

	always_comb begin
		if (parallelMode) begin
			next_dcs     = pinSync[3];
			next_format  = pinSync[4] ? dad_pkg::DAD_DDR_LVDS : dad_pkg::DAD_FULL_CMOS;
			next_power   = {pinSync[5], pinSync[6]};
			next_current = dad_pkg::DAD_CUR_PAR;
			next_term    = 1'b0;
			next_phase   = 2'h0;
		end else begin
			next_dcs     = cfgBus.timingReg[dad_pkg::DAD_DCS_BIT];
			next_format  = cfgBus.outputReg[dad_pkg::DAD_MODE_LSB +: 2];
			next_power   = cfgBus.powerReg[dad_pkg::DAD_POW_LSB +: 2];
			next_current = cfgBus.outputReg[dad_pkg::DAD_CUR_LSB +: 3];
			next_term    = cfgBus.outputReg[dad_pkg::DAD_TERM_BIT];
			next_phase   = cfgBus.timingReg[dad_pkg::DAD_PHASE_LSB +: 2];
		end
		// the unused format code falls back to full rate
		if (next_format == 2'b11) begin
			next_format = dad_pkg::DAD_FULL_CMOS;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			outputFormat   <= dad_pkg::DAD_FULL_CMOS;
			dcsEnable      <= 1'b0;
			powerState     <= dad_pkg::DAD_POW_RUN;
			lvdsCurrent    <= 3'h0;
			lvdsTermEnable <= 1'b0;
			phaseSel       <= 2'h0;
			serialMode     <= 1'b0;
		end else begin
			outputFormat   <= next_format;
			dcsEnable      <= next_dcs;
			powerState     <= next_power;
			lvdsCurrent    <= next_current;
			lvdsTermEnable <= next_term & (next_format == dad_pkg::DAD_DDR_LVDS);
			phaseSel       <= next_phase;
			serialMode     <= strapTaken & ~parallelMode;
		end
	end

	// ------------------------------------------------------------------
	// encode edges
	// ------------------------------------------------------------------
	logic encLevel;
	logic encPrev;
	logic encRise;
	logic encFall;
	logic doubleRate;
	logic running;

	// single-ended use ties the complement low, so this covers both
	assign encLevel   = pinSync[0] & ~pinSync[1];
	assign encRise    = encLevel & ~encPrev;
	assign encFall    = ~encLevel & encPrev;
	assign doubleRate = outputFormat != dad_pkg::DAD_FULL_CMOS;
	assign running    = powerState == dad_pkg::DAD_POW_RUN;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			encPrev <= 1'b0;
		end else begin
			encPrev <= encLevel;
		end
	end

	// ------------------------------------------------------------------
	// sample pipeline
	// ------------------------------------------------------------------
	logic [15:0] heldCh1;
	logic [15:0] heldCh2;
	logic [1:0]  heldOver;
	logic [15:0] outCh1;
	logic [15:0] outCh2;
	logic [1:0]  outOver;

	// both words move together, so they reach the pins in one period
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			heldCh1  <= 16'h0000;
			heldCh2  <= 16'h0000;
			heldOver <= 2'h0;
		end else if (encRise) begin
			heldCh1  <= ch1Conv;
			heldCh2  <= ch2Conv;
			heldOver <= {ch2OverRange, ch1OverRange};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			outCh1  <= 16'h0000;
			outCh2  <= 16'h0000;
			outOver <= 2'h0;
		end else if (encFall) begin
			outCh1  <= heldCh1;
			outCh2  <= heldCh2;
			outOver <= heldOver;
		end
	end

	// ------------------------------------------------------------------
	// even and odd bit split
	// ------------------------------------------------------------------
	logic [7:0] ch1Even;
	logic [7:0] ch1Odd;
	logic [7:0] ch2Even;
	logic [7:0] ch2Odd;

	genvar g;
	generate
		for (g = 0; g < dad_pkg::DAD_PAIR_W; g++) begin : gPair
			assign ch1Even[g] = heldCh1[2*g];
			assign ch2Even[g] = heldCh2[2*g];
			assign ch1Odd[g]  = outCh1[2*g+1];
			assign ch2Odd[g]  = outCh2[2*g+1];
		end
	endgenerate

	// ------------------------------------------------------------------
	// full-rate outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ch1SampleBus <= 16'h0000;
			ch2SampleBus <= 16'h0000;
			ch1RangeFlag <= 1'b0;
			ch2RangeFlag <= 1'b0;
		end else if (!running || doubleRate) begin
			ch1SampleBus <= 16'h0000;
			ch2SampleBus <= 16'h0000;
			ch1RangeFlag <= 1'b0;
			ch2RangeFlag <= 1'b0;
		end else if (encFall) begin
			ch1SampleBus <= heldCh1;
			ch2SampleBus <= heldCh2;
			ch1RangeFlag <= heldOver[0];
			ch2RangeFlag <= heldOver[1];
		end
	end

	// ------------------------------------------------------------------
	// double-rate outputs, cmos and differential alike
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ch1PairedBus    <= 8'h00;
			ch2PairedBus    <= 8'h00;
			sharedRangeFlag <= 1'b0;
		end else if (!running || !doubleRate) begin
			ch1PairedBus    <= 8'h00;
			ch2PairedBus    <= 8'h00;
			sharedRangeFlag <= 1'b0;
		end else if (encFall) begin
			ch1PairedBus    <= ch1Even;
			ch2PairedBus    <= ch2Even;
			sharedRangeFlag <= heldOver[1];
		end else if (encRise) begin
			ch1PairedBus    <= ch1Odd;
			ch2PairedBus    <= ch2Odd;
			sharedRangeFlag <= outOver[0];
		end
	end

	// ------------------------------------------------------------------
	// forwarded clock with programmable lag
	// ------------------------------------------------------------------
	logic [2:0] encDelay;
	logic       next_fwd;

	// lag is in whole system cycles; fine enough against a slow encode
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			encDelay <= 3'h0;
		end else begin
			encDelay <= {encDelay[1:0], encLevel};
		end
	end

	always_comb begin
		case (phaseSel)
			2'h0:    next_fwd = encLevel;
			2'h1:    next_fwd = encDelay[0];
			2'h2:    next_fwd = encDelay[1];
			2'h3:    next_fwd = encDelay[2];
			default: next_fwd = encLevel;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fwdClockTrue <= 1'b0;
			fwdClockComp <= 1'b1;
		end else if (!running) begin
			fwdClockTrue <= 1'b0;
			fwdClockComp <= 1'b1;
		end else begin
			fwdClockTrue <= next_fwd;
			fwdClockComp <= ~next_fwd;
		end
	end
endmodule

/* File: testbench/dad_checker.sv */
/* pin-level checks for the converter port.
 * assumes it is bound to the port top and sees its pins only. */
`timescale 1ns/1ps
module dad_checker (
	// system
	input wire logic        clock,
	input wire logic        reset_n,
	// config pins
	input wire logic        csN,
	input wire logic        sck,
	input wire logic        progModeStrap,
	input wire logic        sdoOut,
	input wire logic        sdoOe,
	input wire logic        serialMode,
	// outputs
	input wire logic [15:0] ch1SampleBus,
	input wire logic [7:0]  ch1PairedBus,
	input wire logic        fwdClockTrue,
	input wire logic        fwdClockComp,
	input wire logic [1:0]  outputFormat,
	input wire logic        dcsEnable,
	input wire logic [1:0]  powerState,
	input wire logic        lvdsTermEnable
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_comp_inv; fwdClockComp == !fwdClockTrue; endproperty
	a_comp_inv: assert property (p_comp_inv) else $error("complement clock wrong");
	// lag up to three cycles may follow the data change
	property p_full_fall; outputFormat == 2'h0 && $stable(outputFormat) && powerState == 2'h0
		&& $changed(ch1SampleBus) |-> ##[0:3] $fell(fwdClockTrue); endproperty
	a_full_fall: assert property (p_full_fall) else $error("full data not on clock fall");
	property p_ddr_edge; outputFormat inside {2'h1, 2'h2} && $stable(outputFormat) && powerState == 2'h0
		&& $changed(ch1PairedBus) |-> ##[0:3] $changed(fwdClockTrue); endproperty
	a_ddr_edge: assert property (p_ddr_edge) else $error("paired data off clock edge");
	property p_ddr_quiet; outputFormat inside {2'h1, 2'h2} && $changed(ch1PairedBus)
		|-> ch1SampleBus == 16'h0000; endproperty
	a_ddr_quiet: assert property (p_ddr_quiet) else $error("full bus live in paired mode");
	property p_par_fmt; progModeStrap && !serialMode && $rose(sck) |-> ##[1:6] outputFormat == 2'h2; endproperty
	a_par_fmt: assert property (p_par_fmt) else $error("format pin ignored");
	property p_par_dcs; progModeStrap && !serialMode && $fell(csN) |-> ##[1:6] !dcsEnable; endproperty
	a_par_dcs: assert property (p_par_dcs) else $error("stabilizer pin ignored");
	property p_cfg_hold; (serialMode && csN) [*8] |=> $stable(outputFormat) && $stable(dcsEnable); endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed while deselected");
	property p_sdo_od; sdoOe |-> !sdoOut; endproperty
	a_sdo_od: assert property (p_sdo_od) else $error("readback drives high");
	property p_sdo_rel; (serialMode && csN) [*6] |-> !sdoOe; endproperty
	a_sdo_rel: assert property (p_sdo_rel) else $error("readback held after frame");
	property p_term; lvdsTermEnable |-> outputFormat == 2'h2; endproperty
	a_term: assert property (p_term) else $error("termination outside differential");
endmodule

bind dad_converter_port dad_checker dad_checker_i (.clock(clock), .reset_n(reset_n), .csN(csN), .sck(sck),
	.progModeStrap(progModeStrap), .sdoOut(sdoOut), .sdoOe(sdoOe), .serialMode(serialMode),
	.ch1SampleBus(ch1SampleBus), .ch1PairedBus(ch1PairedBus), .fwdClockTrue(fwdClockTrue),
	.fwdClockComp(fwdClockComp), .outputFormat(outputFormat), .dcsEnable(dcsEnable),
	.powerState(powerState), .lvdsTermEnable(lvdsTermEnable));

/* File: testbench/dad_host_model.sv */
/* serial configuration host: frames writes and reads on the pins.
 * assumes a pull-up on the open-drain readback line. */
`timescale 1ns/1ps
module dad_host_model (
	// system
	input wire logic clock,
	// serial pins
	output logic     csN,
	output logic     sck,
	output logic     sdi,
	input wire logic sdoOe,
	output logic     sdoLine
);
	// pull-up wins unless the device sinks the line
	assign sdoLine = sdoOe ? 1'h0 : 1'h1;
	initial begin
		csN = 1'h1;
		sck = 1'h0;
		sdi = 1'h0;
	end
	// short nBits aborts the frame early
	task automatic xfer(input logic rd, input logic [6:0] idx, input logic [7:0] wdat, input int nBits,
		output logic [7:0] rdat);
		logic [15:0] frame;
		frame = {rd, idx, wdat};
		rdat = 8'h00;
		@(posedge clock);
		csN <= 1'h0;
		repeat (13) @(posedge clock);
		for (int k = 0; k < nBits; k++) begin
			sdi <= frame[15 - k];
			repeat (6) @(posedge clock);
			sck <= 1'h1;
			repeat (12) @(posedge clock);
			if (k >= 8)
				rdat = {rdat[6:0], sdoLine};
			sck <= 1'h0;
			repeat (7) @(posedge clock);
		end
		repeat (6) @(posedge clock);
		csN <= 1'h1;
		sdi <= ~sdi;
		repeat (10) @(posedge clock);
	endtask
endmodule

/* File: testbench/tb.sv */
/* self-checking bench: serial and parallel setup, full and paired formats.
 * assumes host model and checker are compiled first. */
`timescale 1ns/1ps
module tb;
	logic        clock = 1'h0;
	logic        reset_n = 1'h0;
	logic        encodeClkPos = 1'h0;
	logic        encodeClkNeg = 1'h0;
	logic [15:0] ch1Conv = 16'h0000;
	logic [15:0] ch2Conv = 16'h0000;
	logic        ch1OverRange = 1'h0;
	logic        ch2OverRange = 1'h0;
	logic        progModeStrap = 1'h0;
	logic        par = 1'h0;
	logic        pCs = 1'h1;
	logic        pSck = 1'h0;
	logic        pSdi = 1'h0;
	logic        pSdo = 1'h0;
	logic        hCs, hSck, hSdi, sdoLine, sdoOut, sdoOe, ch1RangeFlag, ch2RangeFlag, sharedRangeFlag;
	logic        fwdClockTrue, fwdClockComp, dcsEnable, lvdsTermEnable, serialMode;
	logic [15:0] ch1SampleBus, ch2SampleBus;
	logic [7:0]  ch1PairedBus, ch2PairedBus, rdat;
	logic [1:0]  outputFormat, powerState;
	logic [2:0]  lvdsCurrent;
	int          errCount = 0;
	int          testsRun = 0;
	wire         csPin = par ? pCs : hCs;
	wire         sckPin = par ? pSck : hSck;
	wire         sdiPin = par ? pSdi : hSdi;
	wire         sdoPin = par ? pSdo : sdoLine;

	always #2.5 clock = ~clock;

	dad_converter_port dad_converter_port_i (.clock(clock), .reset_n(reset_n), .encodeClkPos(encodeClkPos),
		.encodeClkNeg(encodeClkNeg), .ch1Conv(ch1Conv), .ch2Conv(ch2Conv), .ch1OverRange(ch1OverRange),
		.ch2OverRange(ch2OverRange), .progModeStrap(progModeStrap), .csN(csPin), .sck(sckPin), .sdi(sdiPin),
		.sdoIn(sdoPin), .sdoOut(sdoOut), .sdoOe(sdoOe), .ch1SampleBus(ch1SampleBus), .ch2SampleBus(ch2SampleBus),
		.ch1RangeFlag(ch1RangeFlag), .ch2RangeFlag(ch2RangeFlag), .ch1PairedBus(ch1PairedBus),
		.ch2PairedBus(ch2PairedBus), .sharedRangeFlag(sharedRangeFlag), .fwdClockTrue(fwdClockTrue),
		.fwdClockComp(fwdClockComp), .outputFormat(outputFormat), .dcsEnable(dcsEnable), .powerState(powerState),
		.lvdsCurrent(lvdsCurrent), .lvdsTermEnable(lvdsTermEnable), .serialMode(serialMode));
	dad_host_model dad_host_model_i (.clock(clock), .csN(hCs), .sck(hSck), .sdi(hSdi), .sdoOe(sdoOe),
		.sdoLine(sdoLine));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		testsRun++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic completeRun();
		$display("errors %0d checks %0d", errCount, testsRun);
		if (errCount == 0 && testsRun > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic do_reset(input logic strap);
		@(posedge clock);
		reset_n <= 1'h0;
		progModeStrap <= strap;
		par <= strap;
		repeat (5) @(posedge clock);
		reset_n <= 1'h1;
		repeat (12) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [6:0] idx, input logic [7:0] dat);
		dad_host_model_i.xfer(1'h0, idx, dat, 16, rdat);
		#1;
	endtask
	// one encode period, ends low with outputs settled
	task automatic enc(input logic [15:0] w1, input logic [15:0] w2, input logic f1, input logic f2);
		@(posedge clock);
		ch1Conv <= w1;
		ch2Conv <= w2;
		ch1OverRange <= f1;
		ch2OverRange <= f2;
		repeat (2) @(posedge clock);
		encodeClkPos <= 1'h1;
		repeat (8) @(posedge clock);
		encodeClkPos <= 1'h0;
		repeat (8) @(posedge clock);
		#1;
	endtask
	function automatic logic [7:0] half(input logic [15:0] w, input int odd);
		for (int k = 0; k < 8; k++)
			half[k] = w[2 * k + odd];
	endfunction
	task automatic t_full(input logic [15:0] w1, input logic [15:0] w2, input logic f1, input logic f2);
		enc(w1, w2, f1, f2);
		chk(ch1SampleBus, w1, "ch1 word");
		chk(ch2SampleBus, w2, "ch2 word");
		chk(16'({ch1RangeFlag, ch2RangeFlag}), 16'({f1, f2}), "flags");
		chk(16'(fwdClockTrue), 16'h0, "clock low");
	endtask
	task automatic t_ddr(input logic [7:0] cfg, input logic [15:0] w1, input logic [15:0] w2);
		wr(dad_pkg::DAD_REG_OUTPUT, cfg);
		chk(16'({lvdsTermEnable, lvdsCurrent, outputFormat}), 16'({cfg[5:0]}), "output cfg");
		enc(w1, w2, cfg[1], !cfg[1]);
		chk(16'({ch1PairedBus, ch2PairedBus}), {half(w1, 0), half(w2, 0)}, "even");
		chk(16'(sharedRangeFlag), 16'(!cfg[1]), "ch2 flag");
		@(posedge clock);
		encodeClkPos <= 1'h1;
		repeat (8) @(posedge clock);
		#1;
		chk(16'({ch1PairedBus, ch2PairedBus}), {half(w1, 1), half(w2, 1)}, "odd");
		chk(16'(sharedRangeFlag), 16'(cfg[1]), "ch1 flag");
		@(posedge clock);
		encodeClkPos <= 1'h0;
		repeat (8) @(posedge clock);
	endtask
	task automatic t_phase(input logic [7:0] tcfg, input int lag, input logic [15:0] w);
		int dAt;
		int fAt;
		dAt = -1;
		fAt = -1;
		wr(dad_pkg::DAD_REG_TIMING, tcfg);
		@(posedge clock);
		ch1Conv <= w;
		encodeClkNeg <= 1'h1;
		repeat (2) @(posedge clock);
		encodeClkPos <= 1'h1;
		encodeClkNeg <= 1'h0;
		repeat (8) @(posedge clock);
		encodeClkPos <= 1'h0;
		encodeClkNeg <= 1'h1;
		for (int k = 0; k < 10; k++) begin
			@(posedge clock);
			#1;
			if (dAt < 0 && ch1SampleBus === w)
				dAt = k;
			if (fAt < 0 && fwdClockTrue === 1'h0)
				fAt = k;
		end
		chk(16'(fAt - dAt), 16'(lag), "clock lag");
		chk(16'(dAt), 16'h0002, "data edge");
	endtask
	task automatic t_par();
		@(posedge clock);
		pCs <= 1'h1;
		pSdi <= 1'h1;
		do_reset(1'h1);
		chk(16'({serialMode, dcsEnable, powerState}), 16'h6, "parallel pins");
		@(posedge clock);
		pSck <= 1'h1;
		pCs <= 1'h0;
		pSdi <= 1'h0;
		repeat (8) @(posedge clock);
		#1;
		chk(16'({outputFormat, dcsEnable, powerState}), 16'h10, "parallel change");
	endtask

	initial begin
		do_reset(1'h0);
		chk(16'(serialMode), 16'h1, "serial strap");
		t_full(16'hA5C3, 16'h5A3C, 1'h1, 1'h0);
		t_full(16'h8000, 16'h7FFF, 1'h0, 1'h1);
		t_ddr(8'h01, 16'h3C96, 16'hC369);
		t_ddr(8'h3E, 16'h5AF0, 16'h0FA5);
		wr(dad_pkg::DAD_REG_OUTPUT, 8'h2A);
		dad_host_model_i.xfer(1'h1, dad_pkg::DAD_REG_OUTPUT, 8'h00, 16, rdat);
		chk(16'(rdat), 16'h002A, "readback");
		dad_host_model_i.xfer(1'h0, dad_pkg::DAD_REG_OUTPUT, 8'h00, 10, rdat);
		chk(16'(outputFormat), 16'h0002, "aborted frame");
		wr(dad_pkg::DAD_REG_OUTPUT, 8'h00);
		t_phase(8'h05, 2, 16'h1234);
		t_phase(8'h00, 0, 16'h4321);
		t_par();
		completeRun();
	end
	initial begin
		repeat (40000) @(posedge clock);
		errCount++;
		$display("[ERR] %0t watchdog expired", $time);
		completeRun();
	end
endmodule
